/* File: rtl/vsr_regs.vh */
// Register offsets, field positions, codes and reset values of the regulator register file
`ifndef VSR_REGS_VH
`define VSR_REGS_VH

// Register offsets
`define VSR_ADDR_STATUS 8'h10
`define VSR_ADDR_PEAK 8'h21
`define VSR_ADDR_FAST 8'h24
`define VSR_ADDR_SLOW 8'h25
`define VSR_ADDR_BOOT 8'h26
`define VSR_ADDR_CEIL 8'h30
`define VSR_ADDR_TARGET 8'h31
`define VSR_ADDR_PS 8'h32
`define VSR_ADDR_OFFSET 8'h33
`define VSR_ADDR_CFG 8'h34
`define VSR_ADDR_PTR 8'h35

// Reset values
`define VSR_RST_CEIL 8'hfb
`define VSR_RST_TARGET 8'h00
`define VSR_RST_OFFSET 8'h00
`define VSR_RST_CFG 2'h0
`define VSR_RST_PTR 8'h00
`define VSR_RST_PS_NUM 3'h0
`define VSR_ZERO8 8'h00

// Field positions
`define VSR_CFG_HOLD_BIT 0
`define VSR_CFG_FREEZE_BIT 1
`define VSR_STATUS_SETTLED_BIT 0
`define VSR_PS_TOP_OK 3'h3

// Command codes
`define VSR_CMD_TARGET 3'h1
`define VSR_CMD_STATE 3'h2
`define VSR_CMD_POINTER 3'h3
`define VSR_CMD_DATA 3'h4
`define VSR_CMD_READ 3'h5

// Acknowledge codes
`define VSR_ACK_OK 2'h2
`define VSR_ACK_UNSUP 2'h1
`define VSR_ACK_REJECT 2'h3

// Slew select levels and reports
`define VSR_SLEW_0V 2'h0
`define VSR_SLEW_1V5 2'h1
`define VSR_SLEW_3V 2'h2
`define VSR_SLEW_VCC 2'h3
`define VSR_FAST_LO 8'h0a
`define VSR_FAST_HI 8'h14
`define VSR_SLOW_LO 8'h02
`define VSR_SLOW_HI 8'h04

// Current-limit select levels and per-level peak reports
`define VSR_ILVL_12 5'h0c
`define VSR_ILVL_13 5'h0d
`define VSR_ILVL_14 5'h0e
`define VSR_ILVL_15 5'h0f
`define VSR_ILVL_16 5'h10
`define VSR_ILVL_OFF 5'h11
`define VSR_PEAK_22 8'h16
`define VSR_PEAK_35 8'h23
`define VSR_PEAK_33 8'h21
`define VSR_PEAK_27 8'h1b

`endif

/* File: rtl/vsr_sync.v */
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module vsr_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input wire clk_in,
	input wire resetn_in,
	// Data
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] stage1;

	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			stage1 <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // vsr_sync

/* File: rtl/vsr_regfile.v */
// Function-mapped register file of the dual-output regulator controller
`timescale 1ns/100ps
`include "vsr_regs.vh"

// Contract
// - Slew select level sets fast and slow reports
// - Current levels 12-16 report; 17 latches off
// - Zero boot code waits for target write
// - Nonzero boot code ramps once enabled
// - Target held until next target write
// - Boot code resets to variant default value
// - Target above ceiling ignored, not-supported acknowledge
// - Ceiling writable, resets to FBh
// - Target copy mirrors programmed target, resets 00h
// - States 0-3 accepted, others rejected 11b
// - Power-state register is one-hot per state
// - Signed offset added to target, resets zero
// - Offset bit 7 is sign, two's complement
// - Hold bit clear: zero target drops power-good
// - Hold bit set: power-good stays on zero
// - Freeze bit rejects target and state writes
// - Pointer write stored, addresses later data writes
// - Settled within two steps sets flag, attention
// - Changing target write forces power state 0
module vsr_regfile #(
	parameter [7:0] BOOT_DEFAULT = 8'h00
) (
	// Clock and reset
	input wire clk_in,
	input wire resetn_in,
	// Command port from the serial bus front end
	input wire cmd_valid_in,
	input wire [2:0] cmd_type_in,
	input wire [7:0] cmd_payload_in,
	output reg ack_valid_out,
	output reg [1:0] ack_code_out,
	output reg [7:0] read_data_out,
	// Strap and analog pins
	input wire [1:0] slew_select_input_in,
	input wire [4:0] current_limit_select_input_in,
	input wire enable_in,
	input wire fault_in,
	input wire supply_ok_in,
	input wire near_target_in,
	// Regulator control
	output reg [7:0] dac_code_out,
	output reg regulator_on_out,
	output reg latched_off_out,
	output reg power_good_output_out,
	output reg [7:0] power_state_field_out,
	// Alert
	output reg settled_flag_out,
	output reg attention_n_out
);
	reg rst_s1;
	reg rst_n;
	wire [1:0] slew_s;
	wire [4:0] ilvl_s;
	wire enable_s;
	wire fault_s;
	wire supply_s;
	wire near_s;

	reg [7:0] fast_slew_report;
	reg [7:0] slow_slew_report;
	reg [7:0] peak_current_report;
	reg [7:0] boot_target_code;
	reg [7:0] output_ceiling;
	reg [7:0] target_copy;
	reg [7:0] power_state_field;
	reg [7:0] target_offset;
	reg [1:0] multi_regulator_config;
	reg [7:0] register_pointer;
	reg boot_active;
	reg settle_pending;
	reg [7:0] next_read;
	reg [1:0] next_ack;
	wire [7:0] eff_target;
	wire [7:0] cur_code;
	wire freeze;
	wire pin_fail;

	// Reset release through two flops; assertion stays asynchronous
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	vsr_sync #(.WIDTH(11)) u_pins (
		.clk_in(clk_in),
		.resetn_in(rst_n),
		.async_in({slew_select_input_in, current_limit_select_input_in, enable_in, fault_in, supply_ok_in,
			near_target_in}),
		.sync_out({slew_s, ilvl_s, enable_s, fault_s, supply_s, near_s})
	);

	function [7:0] onehot;
		input [2:0] num;
		begin
			onehot = 8'h01 << num;
		end
	endfunction

	// Clamp a signed sum to the 8-bit code range
	function [7:0] clamp_add;
		input [7:0] base;
		input [7:0] offs;
		reg [9:0] s;
		begin
			s = {2'b00, base} + {{2{offs[7]}}, offs};
			if (s[9])
				clamp_add = `VSR_ZERO8;
			else if (s[8])
				clamp_add = 8'hff;
			else
				clamp_add = s[7:0];
		end
	endfunction

	// A zero target stays zero, so an offset cannot wake an output turned off
	function [7:0] code_of;
		input [7:0] target;
		input [7:0] offs;
		begin
			if (target == `VSR_ZERO8)
				code_of = `VSR_ZERO8;
			else
				code_of = clamp_add(target, offs);
		end
	endfunction

	assign freeze = multi_regulator_config[`VSR_CFG_FREEZE_BIT];
	assign eff_target = code_of(target_copy, target_offset);
	assign cur_code = boot_active ? boot_target_code : eff_target;
	// Any of these drops the output and power good at once
	assign pin_fail = !enable_s || !supply_s || fault_s || latched_off_out;

	// Strap decodes
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			fast_slew_report <= `VSR_FAST_LO;
			slow_slew_report <= `VSR_SLOW_LO;
			peak_current_report <= `VSR_ZERO8;
			latched_off_out <= 1'b0;
		end else begin
			if (slew_s == `VSR_SLEW_1V5 || slew_s == `VSR_SLEW_3V) begin
				fast_slew_report <= `VSR_FAST_HI;
				slow_slew_report <= `VSR_SLOW_HI;
			end else begin
				fast_slew_report <= `VSR_FAST_LO;
				slow_slew_report <= `VSR_SLOW_LO;
			end
			// Levels outside twelve to sixteen report no current
			case (ilvl_s)
				`VSR_ILVL_12: peak_current_report <= `VSR_PEAK_22;
				`VSR_ILVL_13: peak_current_report <= `VSR_PEAK_35;
				`VSR_ILVL_14: peak_current_report <= `VSR_PEAK_33;
				`VSR_ILVL_15: peak_current_report <= `VSR_PEAK_27;
				`VSR_ILVL_16: peak_current_report <= `VSR_PEAK_22;
				default: peak_current_report <= `VSR_ZERO8;
			endcase
			// Latch-off is sticky until the next reset
			if (ilvl_s >= `VSR_ILVL_OFF)
				latched_off_out <= 1'b1;
		end
	end

	// Read mux
	// Unmapped addresses read zero and answer not supported
	always @* begin
		next_read = `VSR_ZERO8;
		next_ack = `VSR_ACK_OK;
		case (cmd_payload_in)
			`VSR_ADDR_STATUS: next_read = {7'h00, settled_flag_out};
			`VSR_ADDR_PEAK: next_read = peak_current_report;
			`VSR_ADDR_FAST: next_read = fast_slew_report;
			`VSR_ADDR_SLOW: next_read = slow_slew_report;
			`VSR_ADDR_BOOT: next_read = boot_target_code;
			`VSR_ADDR_CEIL: next_read = output_ceiling;
			`VSR_ADDR_TARGET: next_read = target_copy;
			`VSR_ADDR_PS: next_read = power_state_field;
			`VSR_ADDR_OFFSET: next_read = target_offset;
			`VSR_ADDR_CFG: next_read = {6'h00, multi_regulator_config};
			`VSR_ADDR_PTR: next_read = register_pointer;
			default: next_ack = `VSR_ACK_UNSUP;
		endcase
	end

	// Command handling
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			boot_target_code <= BOOT_DEFAULT;
			output_ceiling <= `VSR_RST_CEIL;
			target_copy <= `VSR_RST_TARGET;
			power_state_field <= onehot(`VSR_RST_PS_NUM);
			target_offset <= `VSR_RST_OFFSET;
			multi_regulator_config <= `VSR_RST_CFG;
			register_pointer <= `VSR_RST_PTR;
			boot_active <= 1'b1;
			settle_pending <= 1'b0;
			settled_flag_out <= 1'b0;
			attention_n_out <= 1'b1;
			ack_valid_out <= 1'b0;
			ack_code_out <= `VSR_ACK_OK;
			read_data_out <= `VSR_ZERO8;
		end else begin
			ack_valid_out <= cmd_valid_in;
			// Reading the status word clears the flag; a same-cycle settle wins below
			if (cmd_valid_in && cmd_type_in == `VSR_CMD_READ && cmd_payload_in == `VSR_ADDR_STATUS) begin
				settled_flag_out <= 1'b0;
				attention_n_out <= 1'b1;
			end
			if (settle_pending && near_s && !boot_active) begin
				settle_pending <= 1'b0;
				settled_flag_out <= 1'b1;
				attention_n_out <= 1'b0;
			end
			if (cmd_valid_in) begin
				ack_code_out <= `VSR_ACK_OK;
				case (cmd_type_in)
					`VSR_CMD_TARGET: begin
						if (freeze)
							ack_code_out <= `VSR_ACK_REJECT;
						else if (cmd_payload_in > output_ceiling)
							ack_code_out <= `VSR_ACK_UNSUP;
						else begin
							// Boot level is dropped on the first accepted target
							target_copy <= cmd_payload_in;
							boot_active <= 1'b0;
							settle_pending <= 1'b1;
							if (code_of(cmd_payload_in, target_offset) != cur_code)
								power_state_field <= onehot(`VSR_RST_PS_NUM);
						end
					end
					`VSR_CMD_STATE: begin
						if (freeze || cmd_payload_in > {5'h00, `VSR_PS_TOP_OK})
							ack_code_out <= `VSR_ACK_REJECT;
						else
							power_state_field <= onehot(cmd_payload_in[2:0]);
					end
					`VSR_CMD_POINTER:
						register_pointer <= cmd_payload_in;
					`VSR_CMD_DATA: begin
						case (register_pointer)
							`VSR_ADDR_CEIL: output_ceiling <= cmd_payload_in;
							// The offset moves the output too, so the freeze guards it
							`VSR_ADDR_OFFSET: begin
								if (freeze)
									ack_code_out <= `VSR_ACK_REJECT;
								else
									target_offset <= cmd_payload_in;
							end
							`VSR_ADDR_CFG:
								multi_regulator_config <= cmd_payload_in[1:0];
							`VSR_ADDR_PS: begin
								if (freeze || cmd_payload_in > {5'h00, `VSR_PS_TOP_OK})
									ack_code_out <= `VSR_ACK_REJECT;
								else
									power_state_field <= onehot(cmd_payload_in[2:0]);
							end
							default: ack_code_out <= `VSR_ACK_UNSUP;
						endcase
					end
					`VSR_CMD_READ: begin
						read_data_out <= next_read;
						ack_code_out <= next_ack;
					end
					default: ack_code_out <= `VSR_ACK_UNSUP;
				endcase
			end
		end
	end

	// Regulator outputs
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			dac_code_out <= `VSR_ZERO8;
			regulator_on_out <= 1'b0;
			power_good_output_out <= 1'b0;
			power_state_field_out <= onehot(`VSR_RST_PS_NUM);
		end else begin
			power_state_field_out <= power_state_field;
			// Boot ramp only starts with enable; zero boot code keeps output off
			dac_code_out <= enable_s ? cur_code : `VSR_ZERO8;
			regulator_on_out <= !pin_fail && (cur_code != `VSR_ZERO8);
			if (pin_fail)
				power_good_output_out <= 1'b0;
			else if (cur_code != `VSR_ZERO8)
				power_good_output_out <= near_s || power_good_output_out;
			// Hold bit keeps the level through a zero target only
			else if (!boot_active && multi_regulator_config[`VSR_CFG_HOLD_BIT])
				power_good_output_out <= power_good_output_out;
			else
				power_good_output_out <= 1'b0;
		end
	end
endmodule // vsr_regfile

/* File: tb/vsr_regfile_chk.sv */
// Port assertions for the regulator register file
`timescale 1ns/100ps
`include "vsr_regs.vh"
module vsr_regfile_chk (
	// Clock and reset
	input wire clk_in,
	input wire resetn_in,
	// Commands and answers
	input wire cmd_valid_in,
	input wire [2:0] cmd_type_in,
	input wire [7:0] cmd_payload_in,
	input wire ack_valid_out,
	input wire [1:0] ack_code_out,
	// Pins and status
	input wire [4:0] current_limit_select_input_in,
	input wire enable_in,
	input wire fault_in,
	input wire supply_ok_in,
	input wire latched_off_out,
	input wire power_good_output_out,
	input wire [7:0] power_state_field_out,
	input wire settled_flag_out,
	input wire attention_n_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	sequence bad_state_s;
		cmd_valid_in && cmd_type_in == `VSR_CMD_STATE && cmd_payload_in > 8'h03;
	endsequence
	// Five cycles cover the pin synchroniser and the output flop
	sequence power_lost_s;
		(!enable_in || fault_in || !supply_ok_in) [*5];
	endsequence
	ack_follows_a: assert property (cmd_valid_in |=> ack_valid_out)
		else $error("no ack after command");
	ack_cause_a: assert property (ack_valid_out |-> $past(cmd_valid_in))
		else $error("ack without command");
	state_reject_a: assert property (bad_state_s |=> ack_code_out == `VSR_ACK_REJECT)
		else $error("bad state not rejected");
	state_onehot_a: assert property ($onehot(power_state_field_out))
		else $error("power state not one-hot");
	limit_trip_a: assert property ((current_limit_select_input_in >= 5'h11) [*5] |-> latched_off_out)
		else $error("no latch-off at top level");
	latch_hold_a: assert property (latched_off_out |=> latched_off_out)
		else $error("latch-off released");
	good_drop_a: assert property (power_lost_s |-> !power_good_output_out)
		else $error("power good high while off");
	settle_alert_a: assert property ($rose(settled_flag_out) |-> ##[0:1] !attention_n_out)
		else $error("settled without attention");
endmodule // vsr_regfile_chk

bind vsr_regfile vsr_regfile_chk i_vsr_regfile_chk (.clk_in(clk_in), .resetn_in(resetn_in),
	.cmd_valid_in(cmd_valid_in), .cmd_type_in(cmd_type_in), .cmd_payload_in(cmd_payload_in),
	.ack_valid_out(ack_valid_out), .ack_code_out(ack_code_out), .enable_in(enable_in),
	.current_limit_select_input_in(current_limit_select_input_in), .fault_in(fault_in),
	.supply_ok_in(supply_ok_in), .latched_off_out(latched_off_out), .power_good_output_out(power_good_output_out),
	.power_state_field_out(power_state_field_out), .settled_flag_out(settled_flag_out),
	.attention_n_out(attention_n_out));

/* File: tb/vsr_master_model.sv */
// Bus master model that issues one command at a time
`timescale 1ns/100ps
module vsr_master_model (
	// Clock
	input wire clk_in,
	// Command and answer
	output logic cmd_valid_out = 1'b0,
	output logic [2:0] cmd_type_out = 3'h0,
	output logic [7:0] cmd_payload_out = 8'h00,
	input wire ack_valid_in,
	input wire [1:0] ack_code_in,
	input wire [7:0] read_data_in
);
	// Taken at the next edge; the answer is read 1 ns after that same edge
	task automatic send(input logic [2:0] kind, input logic [7:0] data, output logic ok, output logic [1:0] code,
		output logic [7:0] rdata);
		@(posedge clk_in);
		#1;
		cmd_valid_out = 1'b1;
		cmd_type_out = kind;
		cmd_payload_out = data;
		@(posedge clk_in);
		#1;
		{ok, code, rdata} = {ack_valid_in, ack_code_in, read_data_in};
		cmd_valid_out = 1'b0;
		// Idle lines keep moving so a stale payload never looks live
		{cmd_type_out, cmd_payload_out} = ~{kind, data};
	endtask
endmodule // vsr_master_model

/* File: tb/vsr_regfile_test.sv */
// Self-checking bench for the regulator register file
`timescale 1ns/100ps
module vsr_regfile_test;
	localparam logic [7:0] BOOT = 8'hab;
	// Reports per slew level 0V, 1.5V, 3V, supply, and per current level 12 to 16
	localparam logic [31:0] FAST = 32'h0a14140a;
	localparam logic [31:0] SLOW = 32'h02040402;
	localparam logic [39:0] PEAK = 40'h1623211b16;
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [1:0] slew = 2'h0;
	logic [4:0] ilvl = 5'h0c;
	logic en = 1'b0;
	logic fault = 1'b0;
	logic near = 1'b1;
	logic supply = 1'b1;
	wire valid, ack, reg_on, latched, pok, settled, attn_n;
	wire [2:0] kind;
	wire [7:0] payload, rdata_w, dac, ps;
	wire [1:0] code_w;
	int err_total = 0;
	int num_checks = 0;
	int cycles = 0;
	logic ok;
	logic [1:0] code;
	logic [7:0] rdata;

	always #20 clk_in = ~clk_in;
	// The whole run needs well under 1500 cycles
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			end_of_test();
		end
	end

	vsr_regfile #(.BOOT_DEFAULT(BOOT)) i_vsr_regfile (.clk_in(clk_in), .resetn_in(resetn_in),
		.cmd_valid_in(valid), .cmd_type_in(kind), .cmd_payload_in(payload), .ack_valid_out(ack),
		.ack_code_out(code_w), .read_data_out(rdata_w), .slew_select_input_in(slew),
		.current_limit_select_input_in(ilvl), .enable_in(en), .fault_in(fault), .supply_ok_in(supply),
		.near_target_in(near), .dac_code_out(dac), .regulator_on_out(reg_on), .latched_off_out(latched),
		.power_good_output_out(pok), .power_state_field_out(ps), .settled_flag_out(settled),
		.attention_n_out(attn_n));
	vsr_master_model i_vsr_master_model (.clk_in(clk_in), .cmd_valid_out(valid), .cmd_type_out(kind),
		.cmd_payload_out(payload), .ack_valid_in(ack), .ack_code_in(code_w), .read_data_in(rdata_w));

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// Command types: 1 target, 2 state, 3 pointer, 4 data, 5 read
	task automatic cmd(input logic [2:0] t, input logic [7:0] p, input logic [1:0] exp);
		i_vsr_master_model.send(t, p, ok, code, rdata);
		chk("ack_valid", 8'h01, {7'h00, ok});
		chk("ack_code", {6'h00, exp}, {6'h00, code});
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		cmd(3'h5, a, 2'h2);
		chk("read_data", exp, rdata);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d, input logic [1:0] exp);
		cmd(3'h3, a, 2'h2);
		cmd(3'h4, d, exp);
	endtask
	task automatic offs(input logic [7:0] d, input logic [7:0] exp);
		wreg(8'h33, d, 2'h2);
		wait_cyc(2);
		chk("dac offset", exp, dac);
	endtask
	task automatic end_of_test();
		if (err_total == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk_in);
		#1;
		resetn_in = 1'b1;
		wait_cyc(4);
		rd(8'h30, 8'hfb);
		rd(8'h31, 8'h00);
		rd(8'h33, 8'h00);
		rd(8'h32, 8'h01);
		rd(8'h26, BOOT);
		rd(8'h34, 8'h00);
		wreg(8'h24, 8'hff, 2'h1);
		wreg(8'h00, 8'hff, 2'h1);
		cmd(3'h0, 8'h00, 2'h1);
		cmd(3'h5, 8'h00, 2'h1);
		chk("read_data", 8'h00, rdata);
		for (int i = 0; i < 4; i++) begin
			slew = i[1:0];
			wait_cyc(4);
			rd(8'h24, FAST[31-8*i -: 8]);
			rd(8'h25, SLOW[31-8*i -: 8]);
		end
		for (int i = 0; i < 5; i++) begin
			ilvl = 5'h0c + i[4:0];
			wait_cyc(4);
			rd(8'h21, PEAK[39-8*i -: 8]);
		end
		en = 1'b1;
		wait_cyc(5);
		chk("boot dac", BOOT, dac);
		cmd(3'h1, 8'h40, 2'h2);
		wait_cyc(2);
		chk("dac", 8'h40, dac);
		chk("settled", 8'h01, {7'h00, settled});
		chk("attention_n", 8'h00, {7'h00, attn_n});
		rd(8'h10, 8'h01);
		wait_cyc(1);
		chk("settled cleared", 8'h00, {7'h00, settled});
		near = 1'b0;
		cmd(3'h1, 8'h48, 2'h2);
		wait_cyc(3);
		chk("settled early", 8'h00, {7'h00, settled});
		chk("attention_n early", 8'h01, {7'h00, attn_n});
		near = 1'b1;
		wait_cyc(3);
		chk("settled late", 8'h01, {7'h00, settled});
		wreg(8'h30, 8'h50, 2'h2);
		rd(8'h30, 8'h50);
		cmd(3'h1, 8'h51, 2'h1);
		rd(8'h31, 8'h48);
		cmd(3'h1, 8'h50, 2'h2);
		offs(8'hfe, 8'h4e);
		offs(8'h81, 8'h00);
		offs(8'h03, 8'h53);
		offs(8'h00, 8'h50);
		for (int n = 0; n < 8; n++) begin
			cmd(3'h2, n[7:0], n < 4 ? 2'h2 : 2'h3);
			wait_cyc(1);
			chk("power state", n < 4 ? 8'h01 << n : 8'h08, ps);
		end
		wreg(8'h32, 8'h02, 2'h2);
		wait_cyc(1);
		chk("power state", 8'h04, ps);
		cmd(3'h1, 8'h30, 2'h2);
		wait_cyc(1);
		chk("power state", 8'h01, ps);
		wreg(8'h34, 8'h02, 2'h2);
		cmd(3'h1, 8'h20, 2'h3);
		cmd(3'h2, 8'h01, 2'h3);
		wreg(8'h33, 8'h05, 2'h3);
		wreg(8'h32, 8'h00, 2'h3);
		rd(8'h33, 8'h00);
		rd(8'h31, 8'h30);
		wreg(8'h34, 8'hfc, 2'h2);
		rd(8'h34, 8'h00);
		cmd(3'h1, 8'h20, 2'h2);
		wreg(8'h33, 8'h03, 2'h2);
		cmd(3'h1, 8'h00, 2'h2);
		wait_cyc(3);
		chk("power good", 8'h00, {7'h00, pok});
		chk("regulator on", 8'h00, {7'h00, reg_on});
		chk("dac zero", 8'h00, dac);
		wreg(8'h34, 8'h01, 2'h2);
		cmd(3'h1, 8'h20, 2'h2);
		wait_cyc(4);
		chk("power good", 8'h01, {7'h00, pok});
		cmd(3'h1, 8'h00, 2'h2);
		wait_cyc(3);
		chk("power good", 8'h01, {7'h00, pok});
		supply = 1'b0;
		wait_cyc(5);
		chk("power good", 8'h00, {7'h00, pok});
		chk("regulator on", 8'h00, {7'h00, reg_on});
		supply = 1'b1;
		cmd(3'h1, 8'h20, 2'h2);
		wait_cyc(4);
		chk("power good", 8'h01, {7'h00, pok});
		fault = 1'b1;
		wait_cyc(5);
		chk("power good", 8'h00, {7'h00, pok});
		fault = 1'b0;
		resetn_in = 1'b0;
		wait_cyc(2);
		resetn_in = 1'b1;
		wait_cyc(5);
		chk("boot dac", BOOT, dac);
		rd(8'h30, 8'hfb);
		rd(8'h31, 8'h00);
		rd(8'h33, 8'h00);
		rd(8'h32, 8'h01);
		rd(8'h34, 8'h00);
		ilvl = 5'h11;
		wait_cyc(6);
		chk("latched off", 8'h01, {7'h00, latched});
		end_of_test();
	end
endmodule // vsr_regfile_test
